//--- sram_lane_pkg.sv
package sram_lane_pkg;
	localparam int LANES          = 4;
	localparam int LANE_BITS      = 9;
	localparam int BYTE_BITS      = 8;
	localparam int ADDR_BITS      = 17;
	localparam int SPARE_PINS     = 2;
	localparam int BURST_BITS     = 2;
	localparam logic [1:0] BURST_START = 2'h0;
	localparam int SYNC_STAGES    = 3;
	localparam logic [LANES-1:0] BWE_IDLE = 4'hF;
	typedef enum logic [1:0]
	{
		CYC_IDLE  = 2'b00,
		CYC_READ  = 2'b01,
		CYC_WRITE = 2'b10
	} cycle_e;
endpackage : sram_lane_pkg

//--- sram_lane_mem.sv
`timescale 1ns/10ps
module sram_lane_mem
#(
	parameter int ADDR_W = 17,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
)
(
	input  wire logic                      i_clock,
	input  wire logic                      i_hold,
	input  wire logic [ADDR_W-1:0]         i_addr,
	input  wire logic [LANES-1:0]          i_lane_write,
	input  wire logic [LANES*LANE_W-1:0]   i_wdata,
	output logic      [LANES*LANE_W-1:0]   o_rdata
);
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			// One array per lane, so each array has a single writing process
			logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
			logic [LANE_W-1:0] lane_q;

			always_ff @(posedge i_clock)
			begin
				if (!i_hold)
				begin
					lane_q <= lane_mem[i_addr];
					// A lane is written whole or not at all
					if (i_lane_write[g])
					begin
						lane_mem[i_addr] <= i_wdata[g*LANE_W +: LANE_W];
					end
				end
			end

			assign o_rdata[g*LANE_W +: LANE_W] = lane_q;
		end
	endgenerate
endmodule : sram_lane_mem

//--- sram_cycle_lane_ctrl.sv
`timescale 1ns/10ps
// Function
// - Cycle type from read_write_select at load
// - Cycle type kept for whole burst
// - Byte writes only in write cycles
// - All enables low writes full word
// - Four byte lanes, each own enable
// - Write data captured on rising edge
// - Ninth lane bit stored only if x36
// - burst_order_select low linear, high interleaved
// - Spare address pins are ignored
// - Load on low advance_load, else advance
// - Enables with address, apply to next data
// - Low address bits seed burst counter
// - Clock suspend freezes all state but the burst order sync
module sram_cycle_lane_ctrl
#(
	parameter int  ADDR_W    = sram_lane_pkg::ADDR_BITS,
	parameter bit  WIDE_X36  = 1'b1
)
(
	input  wire logic                                   i_clock,
	input  wire logic                                   i_rst_n,
	input  wire logic                                   i_clock_suspend_n,
	input  wire logic                                   i_advance_load_n,
	input  wire logic                                   i_read_write_select_n,
	input  wire logic [ADDR_W-1:0]                      i_address,
	input  wire logic [sram_lane_pkg::SPARE_PINS-1:0]   i_spare_address_pin,
	input  wire logic                                   i_burst_order_select,
	input  wire logic                                   i_byte_write_enable_a_n,
	input  wire logic                                   i_byte_write_enable_b_n,
	input  wire logic                                   i_byte_write_enable_c_n,
	input  wire logic                                   i_byte_write_enable_d_n,
	input  wire logic [sram_lane_pkg::LANE_BITS-1:0]    i_data_lane_a,
	input  wire logic [sram_lane_pkg::LANE_BITS-1:0]    i_data_lane_b,
	input  wire logic [sram_lane_pkg::LANE_BITS-1:0]    i_data_lane_c,
	input  wire logic [sram_lane_pkg::LANE_BITS-1:0]    i_data_lane_d,
	output logic      [sram_lane_pkg::LANE_BITS-1:0]    o_data_lane_a,
	output logic      [sram_lane_pkg::LANE_BITS-1:0]    o_data_lane_b,
	output logic      [sram_lane_pkg::LANE_BITS-1:0]    o_data_lane_c,
	output logic      [sram_lane_pkg::LANE_BITS-1:0]    o_data_lane_d,
	output logic      [sram_lane_pkg::LANES-1:0]        o_data_lane_oe_n,
	output logic                                        o_cycle_is_write
);
	import sram_lane_pkg::*;

	localparam int WORD_W = LANES * LANE_BITS;

	logic                     hold;
	logic [SYNC_STAGES-1:0]   order_sync;
	logic                     order_interleaved;
	cycle_e                   cycle;
	logic [ADDR_W-1:0]        base_addr;
	logic [BURST_BITS-1:0]    start_low;
	logic [BURST_BITS-1:0]    beat;
	logic                     op_valid;
	logic                     op_write;
	logic [ADDR_W-1:0]        op_addr;
	logic [LANES-1:0]         op_bwe;
	logic                     rd_pending;
	logic [ADDR_W-1:0]        next_addr;
	logic [BURST_BITS-1:0]    next_low;
	logic [BURST_BITS-1:0]    next_beat;
	logic [LANES-1:0]         lane_write;
	logic [WORD_W-1:0]        wdata;
	logic [WORD_W-1:0]        rdata;
	logic [WORD_W-1:0]        parity_mask;

	assign hold = !i_clock_suspend_n;

	// Strap is asynchronous to the bus; two agreeing stages filter glitches
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			order_sync        <= '1;
			order_interleaved <= 1'b1;
		end
		else
		begin
			order_sync <= {order_sync[SYNC_STAGES-2:0], i_burst_order_select};
			if (order_sync[SYNC_STAGES-1] == order_sync[SYNC_STAGES-2])
			begin
				order_interleaved <= order_sync[SYNC_STAGES-1];
			end
		end
	end

	// Burst address generation
	always_comb
	begin
		next_beat = beat + 2'h1;
		if (order_interleaved)
		begin
			next_low = start_low ^ next_beat;
		end
		else
		begin
			next_low = start_low + next_beat;
		end
		if (!i_advance_load_n)
		begin
			next_addr = i_address;
		end
		else
		begin
			next_addr = {base_addr[ADDR_W-1:BURST_BITS], next_low};
		end
	end

	// Spare address pins never reach the decode
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cycle     <= CYC_IDLE;
			base_addr <= '0;
			start_low <= BURST_START;
			beat      <= BURST_START;
		end
		else if (!hold)
		begin
			if (!i_advance_load_n)
			begin
				cycle     <= i_read_write_select_n ? CYC_READ : CYC_WRITE;
				base_addr <= i_address;
				start_low <= i_address[BURST_BITS-1:0];
				beat      <= BURST_START;
			end
			else
			begin
				beat <= next_beat;
			end
		end
	end

	// Address phase staged so enables meet the data of the next edge
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			op_valid <= 1'b0;
			op_write <= 1'b0;
			op_addr  <= '0;
			op_bwe   <= BWE_IDLE;
		end
		else if (!hold)
		begin
			if (!i_advance_load_n)
			begin
				op_valid <= 1'b1;
				op_write <= !i_read_write_select_n;
			end
			else
			begin
				op_valid <= (cycle != CYC_IDLE);
				op_write <= (cycle == CYC_WRITE);
			end
			op_addr <= next_addr;
			op_bwe  <= {i_byte_write_enable_d_n, i_byte_write_enable_c_n,
				i_byte_write_enable_b_n, i_byte_write_enable_a_n};
		end
	end

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			assign lane_write[g] = op_valid && op_write && !op_bwe[g];
			assign parity_mask[g*LANE_BITS +: LANE_BITS] =
				{WIDE_X36, {BYTE_BITS{1'b1}}};
		end
	endgenerate

	assign wdata = {i_data_lane_d, i_data_lane_c, i_data_lane_b, i_data_lane_a}
		& parity_mask;

	sram_lane_mem #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_BITS)
	) u_mem (
		.i_clock      (i_clock),
		.i_hold       (hold),
		.i_addr       (op_addr),
		.i_lane_write (lane_write),
		.i_wdata      (wdata),
		.o_rdata      (rdata)
	);

	// Read data lands one edge after the data phase; drive it from a register
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rd_pending       <= 1'b0;
			o_data_lane_a    <= '0;
			o_data_lane_b    <= '0;
			o_data_lane_c    <= '0;
			o_data_lane_d    <= '0;
			o_data_lane_oe_n <= '1;
			o_cycle_is_write <= 1'b0;
		end
		else if (!hold)
		begin
			rd_pending       <= op_valid && !op_write;
			// Lanes move only in a read data phase; in all other cycles they hold their last value
			if (rd_pending)
			begin
				o_data_lane_a <= rdata[0*LANE_BITS +: LANE_BITS] & parity_mask[8:0];
				o_data_lane_b <= rdata[1*LANE_BITS +: LANE_BITS] & parity_mask[8:0];
				o_data_lane_c <= rdata[2*LANE_BITS +: LANE_BITS] & parity_mask[8:0];
				o_data_lane_d <= rdata[3*LANE_BITS +: LANE_BITS] & parity_mask[8:0];
			end
			o_data_lane_oe_n <= {LANES{!rd_pending}};
			// Type shows from the load edge itself, in step with the cycle register
			if (!i_advance_load_n)
			begin
				o_cycle_is_write <= !i_read_write_select_n;
			end
			else
			begin
				o_cycle_is_write <= (cycle == CYC_WRITE);
			end
		end
	end
endmodule : sram_cycle_lane_ctrl

//--- sram_host_strap.sv
`timescale 1ns/10ps
module sram_host_strap
(
	input  wire logic i_rst_n,
	input  wire logic i_order,
	output logic      o_burst_order_select
);
	// Strap moves only while the device is held in reset
	always_latch
	begin
		if (!i_rst_n)
		begin
			o_burst_order_select = i_order;
		end
	end
endmodule : sram_host_strap

//--- sram_cycle_lane_ctrl_sva.sv
`timescale 1ns/10ps
module sram_lane_chk
#(
	parameter bit WIDE_X36 = 1'b1
)
(
	input wire logic       i_clock,
	input wire logic       i_rst_n,
	input wire logic       i_clock_suspend_n,
	input wire logic       i_advance_load_n,
	input wire logic       i_read_write_select_n,
	input wire logic [8:0] o_data_lane_a,
	input wire logic [3:0] o_data_lane_oe_n,
	input wire logic       o_cycle_is_write
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire logic s  = i_clock_suspend_n;
	wire logic ld = s && !i_advance_load_n;
	wire logic wr = !i_read_write_select_n;
	property p_wr; ld && wr |=> o_cycle_is_write; endproperty
	a_wr: assert property (p_wr) else $error("write load missed");
	property p_rd; ld && !wr |=> !o_cycle_is_write; endproperty
	a_rd: assert property (p_rd) else $error("read load missed");
	property p_keep; s && i_advance_load_n |=> $stable(o_cycle_is_write); endproperty
	a_keep: assert property (p_keep) else $error("type changed mid burst");
	property p_frz;
		!s |=> $stable(o_data_lane_a) && $stable(o_data_lane_oe_n) && $stable(o_cycle_is_write);
	endproperty
	a_frz: assert property (p_frz) else $error("state moved while suspended");
	property p_wr_oe; ld && wr ##1 s ##1 s |=> o_data_lane_oe_n == 4'hF; endproperty
	a_wr_oe: assert property (p_wr_oe) else $error("lanes driven in write");
	property p_rd_oe; ld && !wr ##1 s ##1 s |=> o_data_lane_oe_n == 4'h0; endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("read lanes not driven");
	property p_lanes; o_data_lane_oe_n == 4'h0 || o_data_lane_oe_n == 4'hF; endproperty
	a_lanes: assert property (p_lanes) else $error("lane drive split");
	property p_x32; !WIDE_X36 |-> !o_data_lane_a[8]; endproperty
	a_x32: assert property (p_x32) else $error("ninth bit live in x32");
	cover property (ld && wr);
	cover property (ld && !wr);
	cover property (!s);
endmodule : sram_lane_chk
bind sram_cycle_lane_ctrl sram_lane_chk #(.WIDE_X36(WIDE_X36)) chk
(
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_clock_suspend_n(i_clock_suspend_n),
	.i_advance_load_n(i_advance_load_n),
	.i_read_write_select_n(i_read_write_select_n),
	.o_data_lane_a(o_data_lane_a),
	.o_data_lane_oe_n(o_data_lane_oe_n),
	.o_cycle_is_write(o_cycle_is_write)
);

//--- test_sram_cycle_lane_ctrl.sv
`timescale 1ns/10ps
module test_sram_cycle_lane_ctrl;
	import sram_lane_pkg::*;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        susp = 1'b1;
	logic        adv = 1'b1;
	logic        rw = 1'b1;
	logic        ord = 1'b0;
	logic        strap;
	logic [1:0]  sp = 2'h0;
	logic [16:0] addr = 17'h0_0000;
	logic [3:0]  be = 4'hF;
	logic [35:0] d = 36'h0_0000_0000;
	logic [35:0] q;
	logic [35:0] q32;
	logic [3:0]  oe_n;
	logic        cwr;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	initial forever #2 clock = ~clock;
	sram_host_strap host(.i_rst_n(rst_n), .i_order(ord), .o_burst_order_select(strap));
	sram_cycle_lane_ctrl uut
	(
		.i_clock(clock),
		.i_rst_n(rst_n),
		.i_clock_suspend_n(susp),
		.i_advance_load_n(adv),
		.i_read_write_select_n(rw),
		.i_address(addr),
		.i_spare_address_pin(sp),
		.i_burst_order_select(strap),
		.i_byte_write_enable_a_n(be[0]),
		.i_byte_write_enable_b_n(be[1]),
		.i_byte_write_enable_c_n(be[2]),
		.i_byte_write_enable_d_n(be[3]),
		.i_data_lane_a(d[8:0]),
		.i_data_lane_b(d[17:9]),
		.i_data_lane_c(d[26:18]),
		.i_data_lane_d(d[35:27]),
		.o_data_lane_a(q[8:0]),
		.o_data_lane_b(q[17:9]),
		.o_data_lane_c(q[26:18]),
		.o_data_lane_d(q[35:27]),
		.o_data_lane_oe_n(oe_n),
		.o_cycle_is_write(cwr)
	);
	// Same traffic into a narrow build, whose ninth lane bits must read zero
	sram_cycle_lane_ctrl #(.WIDE_X36(1'b0)) uut_x32
	(
		.i_clock(clock),
		.i_rst_n(rst_n),
		.i_clock_suspend_n(susp),
		.i_advance_load_n(adv),
		.i_read_write_select_n(rw),
		.i_address(addr),
		.i_spare_address_pin(sp),
		.i_burst_order_select(strap),
		.i_byte_write_enable_a_n(be[0]),
		.i_byte_write_enable_b_n(be[1]),
		.i_byte_write_enable_c_n(be[2]),
		.i_byte_write_enable_d_n(be[3]),
		.i_data_lane_a(d[8:0]),
		.i_data_lane_b(d[17:9]),
		.i_data_lane_c(d[26:18]),
		.i_data_lane_d(d[35:27]),
		.o_data_lane_a(q32[8:0]),
		.o_data_lane_b(q32[17:9]),
		.o_data_lane_c(q32[26:18]),
		.o_data_lane_d(q32[35:27]),
		.o_data_lane_oe_n(),
		.o_cycle_is_write()
	);
	task automatic cyc(input logic s, a_n, r_n, input logic [3:0] b, input logic [35:0] v);
		@(posedge clock);
		susp <= s;
		adv <= a_n;
		rw <= r_n;
		be <= b;
		d <= v;
		sp <= v[1:0];
	endtask : cyc
	task automatic chk(input logic [35:0] e);
		#1;
		samples_checked++;
		if (q !== e)
		begin
			$display("BAD lanes exp %h got %h", e, q);
			fail_count++;
		end
		if (q32 !== (e & {4{9'h0FF}}))
		begin
			$display("BAD x32 lanes exp %h got %h", e & {4{9'h0FF}}, q32);
			fail_count++;
		end
		if (oe_n !== 4'h0 || cwr !== 1'b0)
		begin
			$display("BAD read drive exp 0 0 got %h %b", oe_n, cwr);
			fail_count++;
		end
	endtask : chk
	function automatic logic [35:0] pat(input int n);
		pat = {4{1'b1, 4'(n), 4'h9}};
	endfunction : pat
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 200)
		begin
			fail_count++;
			complete_run();
		end
	end
	initial
	begin
		logic [35:0] e;
		for (int o = 0; o < 2; o++)
		begin
			@(posedge clock);
			rst_n <= 1'b0;
			ord <= o[0];
			repeat (2) @(posedge clock);
			rst_n <= 1'b1;
			addr <= 17'h0_0041;
			cyc(0, 0, 0, 4'h0, pat(7));
			repeat (4) cyc(1, 1, 1, 4'hF, pat(8));
			for (int j = 0; j < 5; j++)
				cyc(1, j != 0, 0, (j == 4) ? 4'hF : 4'h0, pat(j - 1));
			addr <= 17'h0_0040;
			for (int j = 0; j < 7; j++)
			begin
				cyc(1, j != 0, j == 0, 4'h0, pat(9));
				if (j >= 3)
					chk(o ? pat((j - 3) ^ 1) : pat(j % 4));
			end
			cyc(1, 0, 0, 4'hE, pat(9));
			cyc(1, 1, 0, 4'hF, {27'h0, 9'h055});
			cyc(1, 0, 1, 4'hF, pat(9));
			repeat (3) cyc(1, 1, 1, 4'hF, pat(9));
			e = o ? pat(1) : pat(3);
			chk({e[35:9], 9'h055});
		end
		complete_run();
	end
endmodule : test_sram_cycle_lane_ctrl
